// File: dac_link_regs.svh
// named constants for the quad dac i2c link
`ifndef DAC_LINK_REGS_SVH
`define DAC_LINK_REGS_SVH
// ==================================================
// bus addressing
`define ADDR_HI5 5'b10011
`define HS_CODE5 5'b00001
`define HS_CODE_LO 3'b000
// ==================================================
// control byte fields
`define CTL_PD 0
`define CTL_SEL_LO 1
`define CTL_SEL_HI 2
`define CTL_LD_LO 4
`define CTL_LD_HI 5
`define CTL_EXT_LO 6
`define CTL_EXT_HI 7
`define LD_DIRECT 2'b01
`define PD_FILL 6'h3f
`define LO_FILL 6'h00
`define BYTE_BITS 4'd8
`define WORD_RESET 12'h000
// ==================================================
// controller registers and fields
`define REG_CMD 8'h00
`define REG_STAT 8'h04
`define REG_RDATA 8'h08
`define CMD_GO 0
`define CMD_RD 1
`define CMD_HS 2
`define CMD_PIN_LO 3
`define CMD_PIN_HI 4
`define ST_BUSY 0
`define ST_ACKERR 1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// ==================================================
// host sequencer timing: quarter bit of 8 clocks
`define QTR_LAST 8'd7
`define STEP_FIRST_HS 4'd0
`define STEP_FIRST_FS 4'd2
`define STEP_CODE 4'd1
`define STEP_PD 4'd7
`define STEP_HI 4'd8
`define STEP_LO 4'd9
`endif

// File: dac_link_pkg.sv
// types for the two ends of the quad dac link: slave states and phases, master operations
package dac_link_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACKW = 3'b010,
		ST_TX = 3'b011,
		ST_ACKR = 3'b100
	} dev_state_t;
	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_CTRL = 2'b01,
		PH_MSB = 2'b10,
		PH_LSB = 2'b11
	} phase_t;
	typedef enum logic [2:0] {
		OP_START = 3'b000,
		OP_WR = 3'b001,
		OP_RDACK = 3'b010,
		OP_RDNACK = 3'b011,
		OP_STOP = 3'b100,
		OP_END = 3'b101
	} host_op_t;
endpackage

// File: dac_i2c_if.sv
// two-wire link between the bus master and the quad dac
interface dac_i2c_if;
	logic hostSclOe;
	logic hostSdaOe;
	logic devSdaOe;
	logic scl;
	logic sda;
	// open-drain wires: any enable pulls the line low
	assign scl = !hostSclOe;
	assign sda = !(hostSdaOe || devSdaOe);
	modport host (output hostSclOe, output hostSdaOe, input scl, input sda);
	modport dev (output devSdaOe, input scl, input sda);
endinterface

// File: sync_edge.sv
// two-flop synchroniser with edge detection
module sync_edge #(parameter int W = 1) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] lvl,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] prev_ff;
	// ==================================================
	// synchroniser chain, idles high like the bus
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '1;
			sync_ff <= '1;
			prev_ff <= '1;
		end else begin
			meta_ff <= din;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end
	// edges seen only on the second and third flops
	assign lvl = sync_ff;
	assign rise = sync_ff & ~prev_ff;
	assign fall = ~sync_ff & prev_ff;
endmodule // sync_edge

// File: quad_dac_slave.sv
// quad dac bus slave: readback, power-down and channel registers
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`include "dac_link_regs.svh"
module quad_dac_slave (
	input wire logic ref_clk,
	input wire logic rst_n,
	dac_i2c_if.dev link,
	input wire logic [1:0] pinAddr,
	input wire logic [1:0] extAddr,
	output logic [47:0] chanValue,
	output logic [3:0] poweredDown,
	output logic [7:0] pdMode,
	output logic hsActive
);
	import dac_link_pkg::*;

	// ==================================================
	// synchronised pins and straps
	logic [5:0] syncLvl;
	logic [5:0] syncRise;
	logic [5:0] syncFall;
	sync_edge #(.W(6)) uSync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din({extAddr, pinAddr, link.sda, link.scl}),
		.lvl(syncLvl),
		.rise(syncRise),
		.fall(syncFall)
	);
	wire sclHi = syncLvl[0];
	wire sclRise = syncRise[0];
	wire sclFall = syncFall[0];
	wire sdaIn = syncLvl[1];
	wire [1:0] pinSync = syncLvl[3:2];
	wire [1:0] extSync = syncLvl[5:4];
	// start and stop: data moves while clock is high
	wire startSeen = syncFall[1] & sclHi;
	wire stopSeen = syncRise[1] & sclHi;

	// ==================================================
	// state
	dev_state_t state_ff;
	dev_state_t nxt_state;
	phase_t phase_ff;
	phase_t nxt_phase;
	logic [3:0] bitCnt_ff;
	logic [3:0] nxt_bitCnt;
	logic [7:0] sh_ff;
	logic [7:0] nxt_sh;
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [7:0] msb_ff;
	logic [7:0] nxt_msb;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;
	logic [1:0] rdIdx_ff;
	logic [1:0] nxt_rdIdx;
	logic rdMode_ff;
	logic nxt_rdMode;
	logic sdaOe_ff;
	logic nxt_sdaOe;
	logic hs_ff;
	logic nxt_hs;
	logic [11:0] tr_ff [4];
	logic [11:0] dr_ff [4];
	logic [3:0] tpd_ff;
	logic [3:0] dpd_ff;

	// ==================================================
	// byte decode
	wire byteDone = sclFall && (bitCnt_ff == `BYTE_BITS);
	wire addrHit = (sh_ff[7:1] == {`ADDR_HI5, pinSync});
	wire isHsCode = (sh_ff[7:3] == `HS_CODE5);
	wire [1:0] selCh = ctrl_ff[`CTL_SEL_HI:`CTL_SEL_LO];
	wire pdFlag = ctrl_ff[`CTL_PD];
	wire [1:0] loadMode = ctrl_ff[`CTL_LD_HI:`CTL_LD_LO];
	wire extHit = (ctrl_ff[`CTL_EXT_HI:`CTL_EXT_LO] == extSync);
	wire [11:0] selTr = tr_ff[selCh];
	// flag set: mode bits only, data kept; clear: full data word
	wire [11:0] newWord = pdFlag ? {msb_ff[7:6], selTr[9:0]} : {2'b00, msb_ff, sh_ff[7:6]};
	wire commit = (state_ff == ST_RX) && byteDone && (phase_ff == PH_LSB) && extHit;
	wire [7:0] firstTx = txByteFor(2'd0, pdFlag, selTr);
	wire [7:0] nextTx = txByteFor(rdIdx_ff, pdFlag, selTr);

	// readback byte by position; flag set adds the power-down byte
	function automatic logic [7:0] txByteFor(input logic [1:0] idx, input logic pd, input logic [11:0] word);
		logic [2:0] k;
		k = {1'b0, idx} + {2'b00, ~pd};
		case (k)
			3'd0: txByteFor = {word[11:10], `PD_FILL};
			3'd1: txByteFor = word[9:2];
			3'd2: txByteFor = {word[1:0], `LO_FILL};
			default: txByteFor = 8'hff;
		endcase
	endfunction

	// ==================================================
	// protocol next-state logic
	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_sh = sh_ff;
		nxt_ctrl = ctrl_ff;
		nxt_msb = msb_ff;
		nxt_tx = tx_ff;
		nxt_rdIdx = rdIdx_ff;
		nxt_rdMode = rdMode_ff;
		nxt_sdaOe = sdaOe_ff;
		nxt_hs = hs_ff;
		if (stopSeen) begin
			nxt_state = ST_IDLE;
			nxt_sdaOe = 1'b0;
			nxt_hs = 1'b0;
		end else if (startSeen) begin
			nxt_state = ST_RX;
			nxt_phase = PH_ADDR;
			nxt_bitCnt = 4'd0;
			nxt_sdaOe = 1'b0;
		end else begin
			case (state_ff)
				ST_RX: begin
					if (sclRise) begin
						nxt_sh = {sh_ff[6:0], sdaIn};
						nxt_bitCnt = bitCnt_ff + 4'd1;
					end else if (byteDone) begin
						nxt_bitCnt = 4'd0;
						nxt_state = ST_ACKW;
						nxt_sdaOe = 1'b1;
						case (phase_ff)
							PH_ADDR: begin
								nxt_rdMode = sh_ff[0];
								nxt_rdIdx = 2'd0;
								nxt_phase = PH_CTRL;
								if (isHsCode) begin
									nxt_hs = 1'b1;
									nxt_state = ST_IDLE;
									nxt_sdaOe = 1'b0;
								end else if (!addrHit) begin
									nxt_state = ST_IDLE;
									nxt_sdaOe = 1'b0;
								end
							end
							PH_CTRL: begin
								nxt_ctrl = sh_ff;
								nxt_phase = PH_MSB;
							end
							PH_MSB: begin
								nxt_msb = sh_ff;
								nxt_phase = PH_LSB;
							end
							default: nxt_phase = PH_MSB;
						endcase
					end
				end
				ST_ACKW: begin
					if (sclFall) begin
						if (rdMode_ff) begin
							nxt_tx = firstTx;
							nxt_sdaOe = !firstTx[7];
							nxt_state = ST_TX;
						end else begin
							nxt_sdaOe = 1'b0;
							nxt_state = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (sclRise) begin
						nxt_bitCnt = bitCnt_ff + 4'd1;
					end else if (byteDone) begin
						nxt_sdaOe = 1'b0;
						nxt_bitCnt = 4'd0;
						nxt_state = ST_ACKR;
					end else if (sclFall) begin
						nxt_tx = {tx_ff[6:0], 1'b1};
						nxt_sdaOe = !tx_ff[6];
					end
				end
				ST_ACKR: begin
					if (sclRise) begin
						if (sdaIn) begin
							nxt_state = ST_IDLE;
						end else begin
							nxt_bitCnt = 4'd1;
							nxt_rdIdx = (rdIdx_ff == 2'd3) ? rdIdx_ff : rdIdx_ff + 2'd1;
						end
					end else if (sclFall && bitCnt_ff == 4'd1) begin
						nxt_tx = nextTx;
						nxt_sdaOe = !nextTx[7];
						nxt_bitCnt = 4'd0;
						nxt_state = ST_TX;
					end
				end
				ST_IDLE: nxt_state = ST_IDLE;
				default: nxt_state = ST_IDLE;
			endcase
		end
	end

	// ==================================================
	// protocol registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			phase_ff <= PH_ADDR;
			bitCnt_ff <= 4'd0;
			sh_ff <= 8'h00;
			ctrl_ff <= 8'h00;
			msb_ff <= 8'h00;
			tx_ff <= 8'hff;
			rdIdx_ff <= 2'd0;
			rdMode_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			hs_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			bitCnt_ff <= nxt_bitCnt;
			sh_ff <= nxt_sh;
			ctrl_ff <= nxt_ctrl;
			msb_ff <= nxt_msb;
			tx_ff <= nxt_tx;
			rdIdx_ff <= nxt_rdIdx;
			rdMode_ff <= nxt_rdMode;
			sdaOe_ff <= nxt_sdaOe;
			hs_ff <= nxt_hs;
		end
	end

	// ==================================================
	// channel registers: temporary then output stage
	for (genvar i = 0; i < 4; i++) begin : gChan
		wire hit = (selCh == 2'(i));
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				tr_ff[i] <= `WORD_RESET;
				dr_ff[i] <= `WORD_RESET;
				tpd_ff[i] <= 1'b0;
				dpd_ff[i] <= 1'b0;
			end else if (commit) begin
				if (hit) begin
					tr_ff[i] <= newWord;
					tpd_ff[i] <= pdFlag;
				end
				if (loadMode == `LD_DIRECT && hit) begin
					dr_ff[i] <= newWord;
					dpd_ff[i] <= pdFlag;
				end else if (loadMode[1]) begin
					dr_ff[i] <= hit ? newWord : tr_ff[i];
					dpd_ff[i] <= hit ? pdFlag : tpd_ff[i];
				end
			end
		end
		// output word and power-down state per channel
		assign chanValue[i*12 +: 12] = dr_ff[i];
		assign poweredDown[i] = dpd_ff[i];
		assign pdMode[i*2 +: 2] = dr_ff[i][11:10];
	end

	assign link.devSdaOe = sdaOe_ff;
	assign hsActive = hs_ff;
endmodule // quad_dac_slave

// File: i2c_dac_master.sv
// bus master end: axi4-lite command registers driving the two-wire link
`include "dac_link_regs.svh"
module i2c_dac_master (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	dac_i2c_if.host link
);
	import dac_link_pkg::*;

	// ==================================================
	// register bus slave
	logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff, rdata_ff, cmd_ff;
	logic [3:0] wStrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic run_ff, ackErr_ff, sclOe_ff, sdaOe_ff;
	logic [7:0] rdPd_ff, rdHi_ff, rdLo_ff, sh_ff, qCnt_ff;
	logic [3:0] step_ff, bit_ff;
	logic [1:0] q_ff;
	logic sdaIn;
	logic sdaLvl;

	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a == `REG_CMD) || (a == `REG_STAT) || (a == `REG_RDATA);
	endfunction

	// write takes address and data in either order
	assign awready = !awHeld_ff && !bvalid_ff;
	assign wready = !wHeld_ff && !bvalid_ff;
	assign arready = !rvalid_ff;
	wire doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
	wire cmdWrite = doWrite && (awAddr_ff == `REG_CMD) && (wStrb_ff == 4'hf) && wData_ff[`CMD_GO] && !run_ff;
	wire [31:0] rdWord = (araddr == `REG_CMD) ? cmd_ff :
		(araddr == `REG_STAT) ? {30'h0, ackErr_ff, run_ff} :
		(araddr == `REG_RDATA) ? {8'h00, rdPd_ff, rdHi_ff, rdLo_ff} : 32'h0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff} <= 4'h0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h0;
			wStrb_ff <= 4'h0;
			bresp_ff <= `RESP_OKAY;
			rresp_ff <= `RESP_OKAY;
			rdata_ff <= 32'h0;
		end else begin
			if (awvalid && awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
			end
			if (doWrite) begin
				{awHeld_ff, wHeld_ff, bvalid_ff} <= 3'b001;
				bresp_ff <= isMapped(awAddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
			if (arvalid && arready) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rdWord;
				rresp_ff <= isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_ff && rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;

	// ==================================================
	// transfer script: one operation per step
	wire isRd = cmd_ff[`CMD_RD];
	wire [7:0] ctrlByte = cmd_ff[15:8];
	wire [6:0] devAddr = {`ADDR_HI5, cmd_ff[`CMD_PIN_HI:`CMD_PIN_LO]};

	function automatic host_op_t stepOp(input logic [3:0] s, input logic rd);
		if (rd) begin
			case (s)
				4'd0, 4'd2, 4'd5: stepOp = OP_START;
				4'd1, 4'd3, 4'd4, 4'd6: stepOp = OP_WR;
				4'd7, 4'd8: stepOp = OP_RDACK;
				4'd9: stepOp = OP_RDNACK;
				4'd10: stepOp = OP_STOP;
				default: stepOp = OP_END;
			endcase
		end else begin
			case (s)
				4'd0, 4'd2: stepOp = OP_START;
				4'd1, 4'd3, 4'd4, 4'd5, 4'd6: stepOp = OP_WR;
				4'd7: stepOp = OP_STOP;
				default: stepOp = OP_END;
			endcase
		end
	endfunction

	function automatic logic [7:0] stepByte(input logic [3:0] s, input logic rd, input logic [31:0] c);
		case (s)
			4'd1: stepByte = {`HS_CODE5, `HS_CODE_LO};
			4'd3: stepByte = {devAddr, 1'b0};
			4'd4: stepByte = ctrlByte;
			4'd5: stepByte = c[23:16];
			4'd6: stepByte = rd ? {devAddr, 1'b1} : c[31:24];
			default: stepByte = 8'hff;
		endcase
	endfunction

	host_op_t op;
	assign op = stepOp(step_ff, isRd);
	wire [3:0] step1 = step_ff + 4'd1;
	wire [3:0] nxtStep = (isRd && !ctrlByte[`CTL_PD] && step1 == `STEP_PD) ? `STEP_HI : step1;
	wire tick = run_ff && (qCnt_ff == `QTR_LAST);
	wire bitEnd = tick && (q_ff == 2'd3);
	wire isByteOp = (op == OP_WR) || (op == OP_RDACK) || (op == OP_RDNACK);
	wire [7:0] rxByte = {sh_ff[6:0], sdaIn};

	// line level wanted in this quarter
	always_comb begin
		case (op)
			OP_START: sdaLvl = (q_ff != 2'd3);
			OP_STOP: sdaLvl = (q_ff == 2'd3);
			OP_WR: sdaLvl = (bit_ff == `BYTE_BITS) ? 1'b1 : sh_ff[7];
			OP_RDACK: sdaLvl = (bit_ff != `BYTE_BITS);
			default: sdaLvl = 1'b1;
		endcase
	end

	sync_edge #(.W(1)) uSda (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din(link.sda),
		.lvl(sdaIn),
		.rise(),
		.fall()
	);

	// ==================================================
	// bit sequencer: four quarters per bit, sample at the last
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{run_ff, ackErr_ff} <= 2'b00;
			cmd_ff <= 32'h0;
			step_ff <= 4'd0;
			bit_ff <= 4'd0;
			q_ff <= 2'd0;
			qCnt_ff <= 8'h00;
			sh_ff <= 8'hff;
			{rdPd_ff, rdHi_ff, rdLo_ff} <= 24'h0;
		end else if (cmdWrite) begin
			run_ff <= 1'b1;
			ackErr_ff <= 1'b0;
			cmd_ff <= wData_ff;
			step_ff <= wData_ff[`CMD_HS] ? `STEP_FIRST_HS : `STEP_FIRST_FS;
			{bit_ff, q_ff, qCnt_ff} <= 14'h0;
		end else if (run_ff && op == OP_END) begin
			run_ff <= 1'b0;
		end else if (run_ff) begin
			qCnt_ff <= tick ? 8'h00 : qCnt_ff + 8'h01;
			if (tick) begin
				q_ff <= q_ff + 2'd1;
			end
			if (bitEnd && (!isByteOp || bit_ff == `BYTE_BITS)) begin
				if (op == OP_WR && sdaIn && step_ff != `STEP_CODE) begin
					ackErr_ff <= 1'b1;
				end
				step_ff <= nxtStep;
				bit_ff <= 4'd0;
				sh_ff <= stepByte(nxtStep, isRd, cmd_ff);
			end else if (bitEnd) begin
				bit_ff <= bit_ff + 4'd1;
				sh_ff <= rxByte;
				if (bit_ff == 4'd7 && op != OP_WR) begin
					if (step_ff == `STEP_PD) rdPd_ff <= rxByte;
					if (step_ff == `STEP_HI) rdHi_ff <= rxByte;
					if (step_ff == `STEP_LO) rdLo_ff <= rxByte;
				end
			end
		end
	end

	// registered pin enables, clock low in the first half of each bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{sclOe_ff, sdaOe_ff} <= 2'b00;
		end else begin
			sclOe_ff <= run_ff && (op != OP_END) && !q_ff[1];
			sdaOe_ff <= run_ff && (op != OP_END) && !sdaLvl;
		end
	end
	assign link.hostSclOe = sclOe_ff;
	assign link.hostSdaOe = sdaOe_ff;
endmodule // i2c_dac_master

// File: quad_dac_link_asserts.sv
// concurrent checks on the two-wire link between the bus master and the quad dac
module quad_dac_link_asserts #(
	parameter logic [6:0] DEV_ADDR = 7'h4e
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hostSclOe,
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// frame tracking
	logic sclQ_ff, sdaQ_ff, rdMode_ff, match_ff, nack_ff;
	logic [3:0] bitCnt_ff;
	logic [7:0] shift_ff, ctrl_ff;
	logic [2:0] byteIdx_ff;
	wire logic sclRise = scl && !sclQ_ff;
	wire logic startSeen = scl && sclQ_ff && sdaQ_ff && !sda;
	wire logic ackRise = sclRise && (bitCnt_ff == 4'd8);
	wire logic rdData = ackRise && rdMode_ff && match_ff && (byteIdx_ff != 3'd0);
	wire logic [2:0] loIdx = ctrl_ff[0] ? 3'd3 : 3'd2;
	// bit counter, restarted by every start, and shifter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{sclQ_ff, sdaQ_ff, bitCnt_ff, shift_ff} <= {2'b11, 4'd0, 8'h00};
		end else begin
			{sclQ_ff, sdaQ_ff} <= {scl, sda};
			if (startSeen) begin
				bitCnt_ff <= 4'd0;
			end else if (sclRise) begin
				bitCnt_ff <= (bitCnt_ff == 4'd9) ? 4'd1 : bitCnt_ff + 4'd1;
				shift_ff <= (bitCnt_ff < 4'd8) ? {shift_ff[6:0], sda} : shift_ff;
			end
		end
	end
	// byte position, direction, address match and the last control byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{byteIdx_ff, rdMode_ff, match_ff, nack_ff, ctrl_ff} <= '0;
		end else if (startSeen) begin
			{byteIdx_ff, nack_ff} <= {3'd0, 1'b0};
		end else if (ackRise) begin
			byteIdx_ff <= byteIdx_ff + 3'd1;
			if (byteIdx_ff == 3'd0) begin
				{match_ff, rdMode_ff} <= {shift_ff[7:1] == DEV_ADDR, shift_ff[0]};
			end
			if (byteIdx_ff == 3'd1 && !rdMode_ff && match_ff) ctrl_ff <= shift_ff;
			if (rdData && sda) nack_ff <= 1'b1;
		end
	end
	// ==================================================
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_HS_NACK: assert property (ackRise && byteIdx_ff == 3'd0 && shift_ff[7:3] == 5'b00001 |-> sda)
		else $error("speed-up code was acknowledged");
	AST_ADDR_ACK: assert property (ackRise && byteIdx_ff == 3'd0 && shift_ff[7:1] == DEV_ADDR |-> devSdaOe [*8])
		else $error("own address not acknowledged");
	AST_ADDR_NACK: assert property (ackRise && byteIdx_ff == 3'd0 && shift_ff[7:1] != DEV_ADDR |-> !devSdaOe)
		else $error("foreign address acknowledged");
	AST_CTRL_ACK: assert property (ackRise && byteIdx_ff != 3'd0 && !rdMode_ff && match_ff |-> devSdaOe)
		else $error("written byte not acknowledged");
	AST_PD_FILL: assert property (rdData && ctrl_ff[0] && byteIdx_ff == 3'd1 |-> shift_ff[5:0] == 6'h3f)
		else $error("power-down byte fill wrong");
	AST_LO_FILL: assert property (rdData && byteIdx_ff == loIdx |-> shift_ff[5:0] == 6'h00)
		else $error("low byte fill wrong");
	AST_QUIET_END: assert property (nack_ff |-> !devSdaOe)
		else $error("device drives after final byte");
	AST_RD_RELEASE: assert property (rdData |-> !devSdaOe)
		else $error("device holds data line in master ack slot");
	AST_SDA_STABLE: assert property ($changed(devSdaOe) |-> !scl)
		else $error("device data changed while clock high");
	AST_HOST_ACK: assert property (rdData && byteIdx_ff != loIdx |-> hostSdaOe)
		else $error("master did not acknowledge a readback byte");
	AST_HOST_NACK: assert property (rdData && byteIdx_ff == loIdx |-> !hostSdaOe)
		else $error("master acknowledged the final low byte");
	cover property (ackRise && byteIdx_ff == 3'd0 && shift_ff[7:3] == 5'b00001);
	cover property (rdData && ctrl_ff[0] && byteIdx_ff == 3'd1);
	cover property (rdData && sda);
endmodule // quad_dac_link_asserts

// File: quad_dac_hs_readback_powerdown_bench.sv
// self-checking bench: bus master and quad dac joined over the two-wire link
`include "dac_link_regs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin $display("ERROR %s exp %0h got %0h", n, e, s); err_count++; end end
module quad_dac_hs_readback_powerdown_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] PIN = 2'b10;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, hsActive;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [47:0] chanValue;
	logic [3:0] poweredDown;
	logic [7:0] pdMode;
	logic [1:0] pinAddr = PIN, extAddr = 2'b01;
	int err_count = 0, cmp_count = 0, cyc = 0;
	logic hsSeen = 1'b0;
	logic [9:0] vals [4] = '{10'h3a5, 10'h15a, 10'h3ff, 10'h001};
	// ==================================================
	// structure
	dac_i2c_if link ();
	i2c_dac_master i_i2c_dac_master (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
	quad_dac_slave i_quad_dac_slave (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .pinAddr(pinAddr),
		.extAddr(extAddr), .chanValue(chanValue), .poweredDown(poweredDown), .pdMode(pdMode), .hsActive(hsActive));
	quad_dac_link_asserts #(.DEV_ADDR({`ADDR_HI5, PIN})) i_quad_dac_link_asserts (.ref_clk(ref_clk),
		.rst_n(rst_n), .hostSclOe(link.hostSclOe), .hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe),
		.scl(link.scl), .sda(link.sda));
	// clock and hang guard
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// remembers that the speed-up code was ever recognised
	always @(posedge ref_clk) begin
		if (hsActive === 1'b1) hsSeen <= 1'b1;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			err_count++;
			summarize();
		end
	end
	// ==================================================
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		{awaddr, wdata, wstrb} <= {a, v, 4'hf};
		{awvalid, wvalid, bready} <= 3'b111;
		fork
			begin
				@(posedge ref_clk iff awready);
				awvalid <= 1'b0;
			end
			begin
				@(posedge ref_clk iff wready);
				wvalid <= 1'b0;
			end
		join
		@(posedge ref_clk iff bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		@(posedge ref_clk iff arready);
		arvalid <= 1'b0;
		@(posedge ref_clk iff rvalid);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	// one link command, waits for busy to come and go
	task automatic op(input logic [7:0] c, m, l, input logic h, rdb, input logic [1:0] p);
		logic seen;
		seen = 1'b0;
		wr(`REG_CMD, {l, m, c, 3'b000, p, h, rdb, 1'b1});
		do begin
			rd(`REG_STAT);
			if (d[`ST_BUSY] === 1'b1) seen = 1'b1;
		end while (!(seen && d[`ST_BUSY] === 1'b0));
	endtask
	function automatic logic [7:0] ctl(input logic [1:0] ld, ch, input logic pd);
		return {extAddr, ld, 1'b0, ch, pd};
	endfunction
	// ==================================================
	// scenarios
	task automatic t_reset();
		`CHK("chanValue", 48'h0, chanValue)
		`CHK("poweredDown", 4'h0, poweredDown)
		`CHK("hsActive", 1'b0, hsActive)
	endtask
	task automatic t_normal();
		for (int ch = 0; ch < 4; ch++) begin
			op(ctl(`LD_DIRECT, ch[1:0], 1'b0), vals[ch][9:2], {vals[ch][1:0], 6'h00}, ch[0], 1'b0, PIN);
			`CHK("word", {2'b00, vals[ch]}, chanValue[12*ch +: 12])
		end
		for (int ch = 0; ch < 4; ch++) begin
			op(ctl(2'b00, ch[1:0], 1'b0), 8'h00, 8'h00, 1'b1, 1'b1, PIN);
			rd(`REG_RDATA);
			`CHK("readback", {vals[ch], 6'h00}, d[15:0])
			`CHK("hs after stop", 1'b0, hsActive)
		end
		`CHK("hs seen", 1'b1, hsSeen)
	endtask
	task automatic t_pdown();
		for (int m = 0; m < 4; m++) begin
			op(ctl(`LD_DIRECT, 2'd2, 1'b1), {m[1:0], 6'h00}, 8'h00, 1'b1, 1'b0, PIN);
			`CHK("pd word", {m[1:0], vals[2]}, chanValue[35:24])
			`CHK("pd state", 1'b1, poweredDown[2])
			`CHK("pd mode", m[1:0], pdMode[5:4])
			op(ctl(2'b00, 2'd2, 1'b1), 8'h00, 8'h00, 1'b0, 1'b1, PIN);
			rd(`REG_RDATA);
			`CHK("pd readback", {m[1:0], 6'h3f, vals[2], 6'h00}, d[23:0])
		end
		op(ctl(`LD_DIRECT, 2'd2, 1'b0), 8'h80, 8'h40, 1'b0, 1'b0, PIN);
		`CHK("resume", 12'h201, chanValue[35:24])
		`CHK("resume state", 1'b0, poweredDown[2])
	endtask
	task automatic t_load();
		op(ctl(2'b00, 2'd0, 1'b0), 8'h11, 8'h80, 1'b0, 1'b0, PIN);
		`CHK("temp only", {2'b00, vals[0]}, chanValue[11:0])
		op(ctl(2'b10, 2'd1, 1'b1), 8'h80, 8'h00, 1'b1, 1'b0, PIN);
		`CHK("all ch0", 12'h046, chanValue[11:0])
		`CHK("all ch1", {2'b10, vals[1]}, chanValue[23:12])
		`CHK("all pd", 4'b0010, poweredDown)
	endtask
	task automatic t_refuse();
		op(ctl(`LD_DIRECT, 2'd3, 1'b0), 8'hff, 8'hc0, 1'b0, 1'b0, 2'b01);
		rd(`REG_STAT);
		`CHK("addr nack", 1'b1, d[`ST_ACKERR])
		op({2'b10, `LD_DIRECT, 1'b0, 2'd3, 1'b0}, 8'hff, 8'hc0, 1'b0, 1'b0, PIN);
		rd(`REG_STAT);
		`CHK("ext acked", 1'b0, d[`ST_ACKERR])
		`CHK("ext no commit", {2'b00, vals[3]}, chanValue[47:36])
		wr(8'h3c, 32'h0);
		`CHK("unmapped wr", `RESP_SLVERR, r)
		rd(8'h3c);
		`CHK("unmapped rd", {`RESP_SLVERR, 32'h0}, {r, d})
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_normal();
		t_pdown();
		t_load();
		t_refuse();
		summarize();
	end
endmodule // quad_dac_hs_readback_powerdown_bench
